// File: src/bscp_pkg.sv
// Package: constants, bus carriers and state record of the board status/control port
package bscp_pkg;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  localparam logic [31:0] PORT_BASE    = 32'hFFF80000;
  localparam int          PORT_SEL_LSB = 17;
  localparam logic [31:0] OREQ_BASE    = 32'hFFFE0000;
  localparam int          OREQ_SEL_LSB = 16;
  localparam int          IDX_LSB      = 1;

  // ----------------------------------------------------------------
  // Register indices (word index, address bits 5:1)
  // ----------------------------------------------------------------
  localparam logic [4:0] IDX_GPIO = 5'h00;
  localparam logic [4:0] IDX_EDGE = 5'h01;
  localparam logic [4:0] IDX_DIR  = 5'h02;
  localparam logic [4:0] IDX_ENA  = 5'h03;
  localparam logic [4:0] IDX_ENB  = 5'h04;
  localparam logic [4:0] IDX_PNDA = 5'h05;
  localparam logic [4:0] IDX_PNDB = 5'h06;
  localparam logic [4:0] IDX_MSKA = 5'h07;
  localparam logic [4:0] IDX_MSKB = 5'h08;
  localparam logic [4:0] IDX_TCTL = 5'h09;
  localparam logic [4:0] IDX_TDAT = 5'h0D;

  // ----------------------------------------------------------------
  // Port bit positions and fixed values
  // ----------------------------------------------------------------
  localparam int GP_RTS  = 0;
  localparam int GP_BERR = 1;
  localparam int GP_LTO  = 2;
  localparam int GP_CTS  = 3;
  localparam int GP_GATE = 4;
  localparam int GP_FAIL = 5;
  localparam int GP_OREQ = 6;
  localparam int GP_SYSF = 7;
  localparam int TMR_TICK  = 0;
  localparam int TMR_WDOG  = 1;
  localparam int TMR_BAUD  = 2;
  localparam int TMR_DELAY = 3;
  localparam logic [2:0] IRQ_LEVEL = 3'h6;

  // Delay-mode prescale per control code; code 1 is the baud setting of 4
  function automatic logic [7:0] prescale(input logic [2:0] code);
    logic [7:0] p;
    p = 8'h04;
    unique case (code)
      3'h1:    p = 8'h04;
      3'h2:    p = 8'h0A;
      3'h3:    p = 8'h10;
      3'h4:    p = 8'h32;
      3'h5:    p = 8'h40;
      3'h6:    p = 8'h64;
      3'h7:    p = 8'hC8;
      default: p = 8'h04;
    endcase
    return p;
  endfunction

  // ----------------------------------------------------------------
  // Carriers and state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } bscp_req_t;

  typedef struct packed {
    logic [15:0] rdata;
    logic        ack;
  } bscp_rsp_t;

  typedef struct packed {
    logic [7:0]      gpdr;
    logic [7:0]      edge_sel;
    logic [7:0]      dir;
    logic [15:0]     ena;
    logic [15:0]     pend;
    logic [15:0]     mask;
    logic [3:0][2:0] ctl;
    logic [3:0][7:0] tdat;
    logic [3:0][7:0] cnt;
    logic [3:0][7:0] pre;
    logic [3:0]      tout;
    logic [7:0]      gp_prev;
    logic            oreq;
    logic [1:0]      rts_sy;
    logic [1:0]      sysf_sy;
    logic [1:0]      rx_sy;
    logic [1:0]      xt_sy;
    logic            xt_prev;
    logic [15:0]     rdata;
    logic            ack;
  } bscp_state_t;

  localparam bscp_state_t STATE_RST = '0;

endpackage

// File: src/bscp_top.sv
// Board status/control port: GPIO glue, interrupt pending logic, timers
// Behaviour
// - Interrupt request at level 6 from timers/serial/GPIO
// - Shares 16-bit word port at FFF80000
// - Swapped debug data pins; carrier/set-ready held asserted
// - Baud clock from timer C, prescale 4
// - Timer A ticks; timer D delay only
// - Timer B high with jumper resets module
// - Five status inputs, three controls, all latchable
// - Control lines pulled high when not outputs
// - Bit 0 reads inverted request-to-send
// - Bus-error line pulses low for fault cycle
// - Local-timeout line pulses high for fault cycle
// - Bit 3 low drives clear-to-send high
// - Bit 4 high or input blocks interrupts
// - Bit 5 high or input signals board fail
// - Bit 6 shows outgoing backplane request, reset clears
// - Bit 7 reads inverted backplane fail line
// - Read of FFFE0000-FFFEFFFF raises backplane request
`timescale 1ns/1ns
module bscp_top (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  input  wire bscp_pkg::bscp_req_t bus_req_i,
  output bscp_pkg::bscp_rsp_t    bus_rsp_o,
  input  wire logic [7:0]        status_byte_i,
  input  wire logic              xtal_i,
  input  wire logic              debug_rx_in_i,
  input  wire logic              debug_request_to_send_i,
  input  wire logic              serial_tx_i,
  input  wire logic [3:0]        serial_irq_i,
  output logic                   serial_rx_o,
  output logic                   debug_baud_clk_o,
  output logic                   debug_tx_out_o,
  output logic                   debug_carrier_detect_o,
  output logic                   debug_set_ready_o,
  output logic                   debug_clear_to_send_o,
  input  wire logic              vme_berr_end_i,
  input  wire logic              rmw_lock_i,
  input  wire logic              local_timeout_end_i,
  input  wire logic              vme_iack_i,
  input  wire logic              sysfail_in_n_i,
  input  wire logic              syscon_i,
  input  wire logic              wdog_jumper_i,
  output logic                   bus_error_status_n_o,
  output logic                   local_timeout_status_o,
  output logic                   vme_irq_o,
  output logic                   interrupt_gate_n_o,
  output logic                   board_fail_drive_o,
  output logic                   fail_led_o,
  output logic                   sysfail_out_o,
  output logic                   sysfail_oe_o,
  output logic                   module_reset_o,
  output logic                   sysreset_out_o,
  output logic                   sysreset_oe_o,
  output logic                   cpu_irq_o,
  output logic [2:0]             cpu_irq_level_o
);
  import bscp_pkg::*;

  bscp_state_t s_q;
  bscp_state_t s_d;
  logic [7:0]  gp_pin;
  logic [7:0]  gp_eff;
  logic [7:0]  gp_edge;
  logic [3:0]  tmo;
  logic [15:0] src;
  logic        port_sel;
  logic        oreq_rd;
  logic [4:0]  idx;
  logic        xt_tick;

  // ----------------------------------------------------------------
  // Pin-side status lines
  // ----------------------------------------------------------------
  // Fault pulses last exactly the fault cycle strobe
  assign bus_error_status_n_o  = ~(vme_berr_end_i | rmw_lock_i);
  assign local_timeout_status_o = local_timeout_end_i | rmw_lock_i;

  // Raw GPIO levels; outputs idle high by board pull-ups
  always_comb begin
    gp_pin          = 8'hFF;
    gp_pin[GP_RTS]  = ~s_q.rts_sy[1];
    gp_pin[GP_BERR] = bus_error_status_n_o;
    gp_pin[GP_LTO]  = local_timeout_status_o;
    gp_pin[GP_OREQ] = s_q.oreq;
    gp_pin[GP_SYSF] = ~s_q.sysf_sy[1];
  end

  // Driven bits follow the data register, others the pin
  assign gp_eff = (s_q.dir & s_q.gpdr) | (~s_q.dir & gp_pin);

  // ----------------------------------------------------------------
  // Per-bit transition detect, polarity chosen by edge register
  // ----------------------------------------------------------------
  for (genvar b = 0; b < 8; b++) begin : g_edge
    assign gp_edge[b] = s_q.edge_sel[b] ? (gp_eff[b] & ~s_q.gp_prev[b])
                                        : (~gp_eff[b] & s_q.gp_prev[b]);
  end

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  assign port_sel = bus_req_i.addr[31:PORT_SEL_LSB] == PORT_BASE[31:PORT_SEL_LSB];
  assign oreq_rd  = bus_req_i.rd &
                    (bus_req_i.addr[31:OREQ_SEL_LSB] == OREQ_BASE[31:OREQ_SEL_LSB]);
  assign idx      = bus_req_i.addr[IDX_LSB +: 5];
  assign xt_tick  = s_q.xt_sy[1] & ~s_q.xt_prev;

  // Interrupt source map: A = gpio7,6,timer A,serial x4,timer B
  assign src = {gp_edge[GP_SYSF], gp_edge[GP_OREQ], tmo[TMR_TICK], serial_irq_i,
                tmo[TMR_WDOG], gp_edge[GP_FAIL], gp_edge[GP_GATE], tmo[TMR_BAUD],
                tmo[TMR_DELAY], gp_edge[3:0]};

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] clr;
    s_d = s_q;
    tmo = 4'h0;
    clr = 16'h0000;
    s_d.ack = 1'b0;
    // Two-stage synchronisers for pins from other domains
    s_d.rts_sy  = {s_q.rts_sy[0], debug_request_to_send_i};
    s_d.sysf_sy = {s_q.sysf_sy[0], sysfail_in_n_i};
    s_d.rx_sy   = {s_q.rx_sy[0], debug_rx_in_i};
    s_d.xt_sy   = {s_q.xt_sy[0], xtal_i};
    s_d.xt_prev = s_q.xt_sy[1];
    s_d.gp_prev = gp_eff;

    // Timers count crystal ticks through a prescaler, toggle on expiry
    for (int t = 0; t < 4; t++) begin
      if (s_q.ctl[t] != 3'h0 && xt_tick) begin
        if (s_q.pre[t] >= prescale(s_q.ctl[t]) - 8'h01) begin
          s_d.pre[t] = 8'h00;
          if (s_q.cnt[t] == 8'h01) begin
            s_d.cnt[t]  = s_q.tdat[t];
            s_d.tout[t] = ~s_q.tout[t];
            tmo[t]      = 1'b1;
          end else begin
            s_d.cnt[t] = s_q.cnt[t] - 8'h01;
          end
        end else begin
          s_d.pre[t] = s_q.pre[t] + 8'h01;
        end
      end
    end

    // Outgoing request: read of its window sets, acknowledge clears
    if (oreq_rd) begin
      s_d.oreq = 1'b1;
    end else if (vme_iack_i) begin
      s_d.oreq = 1'b0;
    end

    // Register access, answered one cycle later
    if (oreq_rd) begin
      s_d.ack   = 1'b1;
      s_d.rdata = 16'h0000;
    end
    if (port_sel && bus_req_i.rd) begin
      s_d.ack   = 1'b1;
      s_d.rdata = {status_byte_i, 8'h00};
      unique case (idx)
        IDX_GPIO: s_d.rdata[7:0] = gp_eff;
        IDX_EDGE: s_d.rdata[7:0] = s_q.edge_sel;
        IDX_DIR:  s_d.rdata[7:0] = s_q.dir;
        IDX_ENA:  s_d.rdata[7:0] = s_q.ena[15:8];
        IDX_ENB:  s_d.rdata[7:0] = s_q.ena[7:0];
        IDX_PNDA: s_d.rdata[7:0] = s_q.pend[15:8];
        IDX_PNDB: s_d.rdata[7:0] = s_q.pend[7:0];
        IDX_MSKA: s_d.rdata[7:0] = s_q.mask[15:8];
        IDX_MSKB: s_d.rdata[7:0] = s_q.mask[7:0];
        default: begin
          if (idx >= IDX_TCTL && idx < IDX_TDAT) begin
            s_d.rdata[7:0] = {5'h00, s_q.ctl[idx[1:0] - 2'h1]};
          end else if (idx >= IDX_TDAT && idx < IDX_TDAT + 5'h04) begin
            s_d.rdata[7:0] = s_q.cnt[idx[1:0] - 2'h1];
          end
        end
      endcase
    end
    if (port_sel && bus_req_i.wr) begin
      s_d.ack = 1'b1;
      unique case (idx)
        IDX_GPIO: s_d.gpdr     = bus_req_i.wdata;
        IDX_EDGE: s_d.edge_sel = bus_req_i.wdata;
        IDX_DIR:  s_d.dir      = bus_req_i.wdata;
        IDX_ENA:  s_d.ena[15:8] = bus_req_i.wdata;
        IDX_ENB:  s_d.ena[7:0]  = bus_req_i.wdata;
        IDX_PNDA: clr[15:8] = ~bus_req_i.wdata;
        IDX_PNDB: clr[7:0]  = ~bus_req_i.wdata;
        IDX_MSKA: s_d.mask[15:8] = bus_req_i.wdata;
        IDX_MSKB: s_d.mask[7:0]  = bus_req_i.wdata;
        default: begin
          if (idx >= IDX_TCTL && idx < IDX_TDAT) begin
            s_d.ctl[idx[1:0] - 2'h1] = bus_req_i.wdata[2:0];
            s_d.pre[idx[1:0] - 2'h1] = 8'h00;
          end else if (idx >= IDX_TDAT && idx < IDX_TDAT + 5'h04) begin
            s_d.tdat[idx[1:0] - 2'h1] = bus_req_i.wdata;
            if (s_q.ctl[idx[1:0] - 2'h1] == 3'h0) begin
              s_d.cnt[idx[1:0] - 2'h1] = bus_req_i.wdata;
            end
          end
        end
      endcase
    end

    // Sticky pending: a new event wins over a clear in the same cycle
    s_d.pend = (s_q.pend & ~clr) | (src & s_q.ena);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      s_q <= STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus_rsp_o.rdata = s_q.rdata;
  assign bus_rsp_o.ack   = s_q.ack;

  // Debug port: names follow the terminal's view, so data is crossed
  assign debug_tx_out_o         = serial_tx_i;
  assign serial_rx_o            = s_q.rx_sy[1];
  assign debug_carrier_detect_o = 1'b1;
  assign debug_set_ready_o      = 1'b1;
  assign debug_baud_clk_o       = s_q.tout[TMR_BAUD];
  assign debug_clear_to_send_o  = ~gp_eff[GP_CTS];

  // Control lines read back through gp_eff, so input mode acts as high
  assign interrupt_gate_n_o = gp_eff[GP_GATE];
  assign cpu_irq_o          = |(s_q.pend & s_q.mask) & ~gp_eff[GP_GATE];
  assign cpu_irq_level_o    = cpu_irq_o ? IRQ_LEVEL : 3'h0;
  assign board_fail_drive_o = gp_eff[GP_FAIL];
  assign fail_led_o         = gp_eff[GP_FAIL];
  assign sysfail_out_o      = 1'b0;
  assign sysfail_oe_o       = gp_eff[GP_FAIL] & ~syscon_i;
  assign vme_irq_o          = s_q.oreq;

  // Watchdog: timer B output high with jumper fitted
  assign module_reset_o = s_q.tout[TMR_WDOG] & wdog_jumper_i;
  assign sysreset_out_o = 1'b0;
  assign sysreset_oe_o  = module_reset_o & syscon_i;

endmodule

// File: tb/bscp_far_model.sv
// Far-side model: backplane interrupt acknowledge and wired fail line
`timescale 1ns/1ns
module bscp_far_model (
  input  wire logic       clk_sys_i,
  input  wire logic       irq_i,
  input  wire logic       fail_oe_i,
  input  wire logic       other_fail_i,
  input  wire logic [5:0] dly_i,
  output logic            iack_o,
  output logic            fail_n_o
);
  logic [5:0] wait_q = '0;
  initial iack_o = 1'h0;
  // Open-drain line with pull-up: low while any board drives it
  assign fail_n_o = !(fail_oe_i || other_fail_i);
  // Slow or prompt acknowledge, delay set by the bench
  always @(posedge clk_sys_i) begin
    iack_o <= 1'h0;
    if (!irq_i || iack_o) begin
      wait_q <= '0;
    end else if (wait_q == dly_i) begin
      iack_o <= 1'h1;
    end else begin
      wait_q <= wait_q + 6'h1;
    end
  end
endmodule

// File: tb/bscp_asserts.sv
// Checker of the board status/control port pin relations
`timescale 1ns/1ns
module bscp_asserts
  import bscp_pkg::*;
(
  input wire logic       clk_sys_i,
  input wire logic       rst_i,
  input wire bscp_req_t  bus_req_i,
  input wire bscp_rsp_t  bus_rsp_o,
  input wire logic       serial_tx_i,
  input wire logic       debug_tx_out_o,
  input wire logic       debug_carrier_detect_o,
  input wire logic       debug_set_ready_o,
  input wire logic       debug_clear_to_send_o,
  input wire logic       vme_berr_end_i,
  input wire logic       rmw_lock_i,
  input wire logic       local_timeout_end_i,
  input wire logic       syscon_i,
  input wire logic       wdog_jumper_i,
  input wire logic       bus_error_status_n_o,
  input wire logic       local_timeout_status_o,
  input wire logic       vme_irq_o,
  input wire logic       interrupt_gate_n_o,
  input wire logic       board_fail_drive_o,
  input wire logic       fail_led_o,
  input wire logic       sysfail_oe_o,
  input wire logic       module_reset_o,
  input wire logic       sysreset_oe_o,
  input wire logic       cpu_irq_o,
  input wire logic [2:0] cpu_irq_level_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // --------------------------------------------------------------
  // Pin relations
  // --------------------------------------------------------------
  ack_port_a: assert property (
    (bus_req_i.rd || bus_req_i.wr) && bus_req_i.addr[31:17] == PORT_BASE[31:17]
    |=> bus_rsp_o.ack) else $error("port access not acknowledged");
  oreq_set_a: assert property (
    bus_req_i.rd && bus_req_i.addr[31:16] == 16'hFFFE |=> vme_irq_o)
    else $error("window read raised no request");
  rst_ctl_a: assert property ($fell(rst_i) |-> interrupt_gate_n_o &&
    board_fail_drive_o && !debug_clear_to_send_o && !vme_irq_o)
    else $error("control defaults wrong after reset");
  gate_block_a: assert property (interrupt_gate_n_o |-> !cpu_irq_o)
    else $error("request passed a closed gate");
  irq_level_a: assert property (cpu_irq_o |-> cpu_irq_level_o == IRQ_LEVEL)
    else $error("wrong request level");
  fail_drive_a: assert property (fail_led_o == board_fail_drive_o &&
    sysfail_oe_o == (board_fail_drive_o && !syscon_i)) else $error("fail drive wrong");
  wdog_rst_a: assert property (sysreset_oe_o == (module_reset_o && syscon_i) &&
    (!module_reset_o || wdog_jumper_i)) else $error("watchdog reset wrong");
  berr_line_a: assert property (
    bus_error_status_n_o == !(vme_berr_end_i || rmw_lock_i)) else $error("bus error line wrong");
  lto_line_a: assert property (
    local_timeout_status_o == (local_timeout_end_i || rmw_lock_i)) else $error("timeout line wrong");
  dbg_pins_a: assert property (debug_tx_out_o == serial_tx_i &&
    debug_carrier_detect_o && debug_set_ready_o) else $error("debug pins wrong");
  cover property (vme_irq_o ##[1:60] !vme_irq_o);
  cover property (cpu_irq_o);
  cover property (module_reset_o);
endmodule
bind bscp_top bscp_asserts u_chk (.*);

// File: tb/board_status_control_port_tb.sv
// Self-checking bench of the board status/control port
`timescale 1ns/1ns
module board_status_control_port_tb;
  import bscp_pkg::*;
  logic       clk_sys_i = 1'h0, rst_i = 1'h1, xtal_i = 1'h0, other_fail = 1'h0;
  logic       debug_rx_in_i = 1'h0, debug_request_to_send_i = 1'h0, serial_tx_i = 1'h0;
  logic       vme_berr_end_i = 1'h0, rmw_lock_i = 1'h0, local_timeout_end_i = 1'h0;
  logic       syscon_i = 1'h0, wdog_jumper_i = 1'h1, oreq_e = 1'h0, ack_v, b0;
  logic       vme_iack_i, sysfail_in_n_i, serial_rx_o, debug_baud_clk_o, debug_tx_out_o;
  logic       debug_carrier_detect_o, debug_set_ready_o, debug_clear_to_send_o, sysfail_out_o;
  logic       bus_error_status_n_o, local_timeout_status_o, vme_irq_o, interrupt_gate_n_o;
  logic       board_fail_drive_o, fail_led_o, sysfail_oe_o, module_reset_o, sysreset_out_o;
  logic       sysreset_oe_o, cpu_irq_o;
  logic [2:0] cpu_irq_level_o;
  logic [3:0] serial_irq_i = 4'h0;
  logic [5:0] iack_dly = 6'h08;
  logic [7:0] status_byte_i = 8'h00, g;
  logic [15:0] rd_v;
  logic [31:0] v;
  bscp_req_t  bus_req_i = '0;
  bscp_rsp_t  bus_rsp_o;
  int         n_errors = 0, n_compared = 0, cyc = 0;

  bscp_top uut (.*);
  bscp_far_model u_far (.clk_sys_i(clk_sys_i), .irq_i(vme_irq_o), .fail_oe_i(sysfail_oe_o),
    .other_fail_i(other_fail), .dly_i(iack_dly), .iack_o(vme_iack_i),
    .fail_n_o(sysfail_in_n_i));

  // Crystal near its real rate, edges kept on falling clock edges
  always #4 clk_sys_i = ~clk_sys_i;
  always #400 xtal_i = ~xtal_i;
  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      complete_run();
    end
  end

  // --------------------------------------------------------------
  // Tasks and expectations
  // --------------------------------------------------------------
  task automatic complete_run();
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] got);
    n_compared++;
    if (got !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, got);
    end
  endtask
  // One-cycle request pulse, answer taken one cycle later
  task automatic acc(input logic w, input logic [31:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    bus_req_i = '{addr: a, rd: !w, wr: w, wdata: d};
    @(negedge clk_sys_i);
    bus_req_i.rd = 1'h0;
    bus_req_i.wr = 1'h0;
    ack_v = bus_rsp_o.ack;
    rd_v = bus_rsp_o.rdata;
  endtask
  task automatic reg_wr(input logic [4:0] i, input logic [7:0] d);
    acc(1'h1, PORT_BASE | {26'h0, i, 1'h0}, d);
    chk("ack", 24'h1, ack_v);
  endtask
  task automatic reg_rd(input logic [4:0] i, input logic [7:0] e);
    repeat (4) @(negedge clk_sys_i);
    acc(1'h0, PORT_BASE | {26'h0, i, 1'h0}, 8'h00);
    chk("rdata", {1'h1, status_byte_i, e}, {ack_v, rd_v});
  endtask
  // Port read: controls read 1 unless driven as outputs
  function automatic logic [7:0] exp_gp(input logic [7:0] dir, input logic [7:0] dat);
    logic [7:0] e;
    e = (dat & dir) | ~dir;
    e[0] = !debug_request_to_send_i;
    e[1] = 1'h1;
    e[2] = 1'h0;
    e[6] = oreq_e;
    e[7] = other_fail | (e[5] & !syscon_i);
    return e;
  endfunction

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    v = $urandom(32'hB0CC);
    repeat (3) @(posedge clk_sys_i);
    @(negedge clk_sys_i);
    rst_i = 1'h0;
    reg_rd(IDX_GPIO, exp_gp(8'h00, 8'h00));
    // Random controls; first pass all controls low, last with pins as inputs
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      if (i == 0) v[15:8] = 8'h00;
      {other_fail, syscon_i, debug_request_to_send_i, debug_rx_in_i, serial_tx_i} = v[4:0];
      status_byte_i = v[31:24];
      g = (i == 7) ? 8'h00 : 8'h38;
      reg_wr(IDX_DIR, g);
      reg_wr(IDX_GPIO, v[15:8]);
      reg_rd(IDX_GPIO, exp_gp(g, v[15:8]));
      chk("ctl", {exp_gp(g, v[15:8]) & 8'h38, 2'h3, v[1]}, {2'h0, board_fail_drive_o,
        interrupt_gate_n_o, !debug_clear_to_send_o, 3'h0, debug_carrier_detect_o,
        debug_set_ready_o, serial_rx_o});
    end
    other_fail = 1'h0;
    reg_wr(IDX_DIR, 8'h38);
    reg_wr(IDX_EDGE, 8'h04);
    reg_wr(IDX_ENB, 8'h06);
    reg_wr(IDX_MSKB, 8'h06);
    // Fault pulses latched, gate open then closed, then cleared
    for (int k = 0; k < 2; k++) begin
      g = k ? 8'h10 : 8'h00;
      reg_wr(IDX_GPIO, g);
      @(negedge clk_sys_i);
      {rmw_lock_i, vme_berr_end_i, local_timeout_end_i} = k ? 3'h4 : 3'h3;
      #1 chk("fault", 24'h1, {bus_error_status_n_o, local_timeout_status_o});
      @(negedge clk_sys_i);
      {rmw_lock_i, vme_berr_end_i, local_timeout_end_i} = 3'h0;
      reg_rd(IDX_GPIO, exp_gp(8'h38, g));
      chk("irq", k ? 24'h0 : 24'hE, {cpu_irq_o, cpu_irq_level_o});
      reg_rd(IDX_PNDB, 8'h06);
      reg_wr(IDX_PNDB, 8'hF9);
      reg_rd(IDX_PNDB, 8'h00);
    end
    // Outgoing request: refused write, then read and acknowledge
    reg_wr(IDX_ENA, 8'h40);
    reg_wr(IDX_EDGE, 8'h00);
    acc(1'h1, 32'hFFFE0000, 8'h00);
    chk("oreq", 24'h0, {ack_v, vme_irq_o});
    iack_dly = 6'h08 + 6'($urandom_range(0, 20));
    acc(1'h0, 32'hFFFE0000 | ($urandom & 32'h0000FFFE), 8'h00);
    chk("oreq", 24'h3, {ack_v, vme_irq_o});
    oreq_e = 1'h1;
    acc(1'h0, PORT_BASE, 8'h00);
    chk("rdata", {1'h1, status_byte_i, exp_gp(8'h38, 8'h10)}, {ack_v, rd_v});
    for (int t = 0; t < 60 && vme_irq_o === 1'h1; t++) @(negedge clk_sys_i);
    oreq_e = 1'h0;
    reg_rd(IDX_GPIO, exp_gp(8'h38, 8'h10));
    reg_rd(IDX_PNDA, 8'h40);
    acc(1'h0, 32'h00001000, 8'h00);
    chk("unmapped", 24'h0, ack_v);
    // Tick timer A and serial events latched in pending A
    reg_wr(IDX_PNDA, 8'h00);
    reg_wr(IDX_ENA, 8'h3E);
    reg_wr(IDX_TDAT, 8'h01);
    reg_wr(IDX_TCTL, 8'h01);
    @(negedge clk_sys_i);
    serial_irq_i = 4'h1 + 4'($urandom_range(0, 14));
    g = {3'h1, serial_irq_i, 1'h0};
    @(negedge clk_sys_i);
    serial_irq_i = 4'h0;
    // Timer A expires after four crystal ticks, about 400 clocks
    repeat (500) @(negedge clk_sys_i);
    reg_rd(IDX_PNDA, g);
    // Watchdog from timer B, baud clock from timer C
    syscon_i = 1'h1;
    reg_wr(IDX_TDAT + 5'h1, 8'h01);
    reg_wr(IDX_TCTL + 5'h1, 8'h01);
    reg_wr(IDX_TDAT + 5'h2, 8'h01);
    reg_wr(IDX_TCTL + 5'h2, 8'h01);
    b0 = debug_baud_clk_o;
    for (int t = 0; t < 3000 && module_reset_o !== 1'h1; t++) @(negedge clk_sys_i);
    chk("wdog", 24'h3, {module_reset_o, sysreset_oe_o});
    chk("drv", 24'h0, {sysfail_out_o, sysreset_out_o});
    for (int t = 0; t < 3000 && debug_baud_clk_o === b0; t++) @(negedge clk_sys_i);
    chk("baud", {23'h0, !b0}, debug_baud_clk_o);
    complete_run();
  end
endmodule
